// File: bidir_io_board.sv
`timescale 1ns/1ps
`default_nettype none
module bidir_io_board #(
  parameter int W = 8
) (
  // Device side
  input wire logic [W-1:0] drv,
  input wire logic [W-1:0] oe,
  // Board side
  input wire logic [W-1:0] ext,
  output logic [W-1:0] pins
);
  // Pad level: device drive, else a held board level
  always_comb pins = (drv & oe) | (ext & ~oe);
endmodule
`default_nettype wire

// File: bidir_io_pkg.sv
// Summary of operation
// - Port reads return pin levels, never latches
// - Every reset sets all direction bits
// - First port: four pins, bits 7-4 zero
// - Second port: eight bidirectional pins
// - Third location: port or plain register
// - Direction loads only by load instruction
// - Direction one floats pin, zero drives latch
// - Latches hold until rewritten
// - Each pin has its own direction bit
// - Bit ops read pins, rewrite the addressed port's whole latch
// - Write at cycle end, read at start
// - Latches undefined at power-on, kept otherwise
`default_nettype none
package bidir_io_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int DATA_W = 8;
  localparam int ADDR_W = 5;
  localparam int BIT_SEL_W = 3;
  localparam int FIRST_PORT_W = 4;
  localparam int SECOND_PORT_W = 8;
  localparam int THIRD_PORT_W = 8;

  // ----------------------------------------------------------------
  // Register file locations
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] FIRST_PORT_ADDR = 5'h05;
  localparam logic [ADDR_W-1:0] SECOND_PORT_ADDR = 5'h06;
  localparam logic [ADDR_W-1:0] THIRD_PORT_ADDR = 5'h07;

  // ----------------------------------------------------------------
  // Reset and fill values
  // ----------------------------------------------------------------
  localparam logic [DATA_W-1:0] DIR_RESET = 8'hFF;
  localparam logic [DATA_W-1:0] DATA_ZERO = 8'h00;
  localparam logic [DATA_W-FIRST_PORT_W-1:0] FIRST_UPPER_FILL = 4'h0;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SEL_NONE = 2'b00,
    SEL_FIRST = 2'b01,
    SEL_SECOND = 2'b10,
    SEL_THIRD = 2'b11
  } port_sel_t;

  typedef struct packed {
    logic [DATA_W-1:0] level;
    logic [DATA_W-1:0] enable;
  } pin_drive_t;

endpackage
`default_nettype wire

// File: bidir_io_ports.sv
`timescale 1ns/1ps
`default_nettype none
module bidir_io_ports
  import bidir_io_pkg::*;
#(
  parameter bit HAS_THIRD_PORT = 1'b1
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,

  // Register file access from the instruction path
  input wire logic [ADDR_W-1:0] file_addr,
  input wire logic file_read,
  input wire logic file_write,
  input wire logic [DATA_W-1:0] file_wdata,
  output logic [DATA_W-1:0] file_rdata,
  output logic file_hit,

  // Bit set and bit clear instructions
  input wire logic bit_set_instruction,
  input wire logic bit_clear_instruction,
  input wire logic [BIT_SEL_W-1:0] bit_sel,

  // Direction load instruction, data from the working register
  input wire logic dir_load,

  // First port pins
  input wire logic [FIRST_PORT_W-1:0] first_port_pins_in,
  output logic [FIRST_PORT_W-1:0] first_port_pins_out,
  output logic [FIRST_PORT_W-1:0] first_port_pins_oe,

  // Second port pins
  input wire logic [SECOND_PORT_W-1:0] second_port_pins_in,
  output logic [SECOND_PORT_W-1:0] second_port_pins_out,
  output logic [SECOND_PORT_W-1:0] second_port_pins_oe,

  // Third port pins
  input wire logic [THIRD_PORT_W-1:0] third_port_pins_in,
  output logic [THIRD_PORT_W-1:0] third_port_pins_out,
  output logic [THIRD_PORT_W-1:0] third_port_pins_oe,

  // Driven pins seen at the opposite level
  output logic [2:0] drive_conflict
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic port_sel_t decode_port(
    input logic [ADDR_W-1:0] addr
  );
    port_sel_t sel;
    sel = SEL_NONE;
    if (addr == FIRST_PORT_ADDR) begin
      sel = SEL_FIRST;
    end else if (addr == SECOND_PORT_ADDR) begin
      sel = SEL_SECOND;
    end else if (addr == THIRD_PORT_ADDR) begin
      sel = SEL_THIRD;
    end
    return sel;
  endfunction

  function automatic logic [DATA_W-1:0] apply_bit(
    input logic [DATA_W-1:0] value,
    input logic [BIT_SEL_W-1:0] idx,
    input logic set_bit
  );
    logic [DATA_W-1:0] result;
    result = value;
    result[idx] = set_bit;
    return result;
  endfunction

  function automatic logic mismatch(
    input logic [DATA_W-1:0] level,
    input logic [DATA_W-1:0] drive,
    input logic [DATA_W-1:0] oe
  );
    return |((level ^ drive) & oe);
  endfunction

  function automatic logic strobe_for(
    input logic en,
    input port_sel_t at,
    input port_sel_t want
  );
    return en && (at == want);
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [FIRST_PORT_W-1:0] first_port_latch;
  logic [SECOND_PORT_W-1:0] second_port_latch;
  logic [THIRD_PORT_W-1:0] third_port_latch;
  logic [FIRST_PORT_W-1:0] first_port_direction;
  logic [SECOND_PORT_W-1:0] second_port_direction;
  logic [THIRD_PORT_W-1:0] third_port_direction;

  logic [FIRST_PORT_W-1:0] first_sync;
  logic [SECOND_PORT_W-1:0] second_sync;
  logic [THIRD_PORT_W-1:0] third_sync;

  port_sel_t sel;
  logic bit_op;
  logic store_en;
  logic [DATA_W-1:0] read_view;
  logic [DATA_W-1:0] next_store;
  logic first_store, second_store, third_store;
  logic first_dir_load, second_dir_load, third_dir_load;
  pin_drive_t first_drive;
  pin_drive_t second_drive;
  pin_drive_t third_drive;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  pin_sync #(
    .WIDTH(FIRST_PORT_W)
  ) first_sync_inst (
    .ref_clk(ref_clk),
    .reset(reset),
    .async_in(first_port_pins_in),
    .sync_out(first_sync)
  );

  pin_sync #(
    .WIDTH(SECOND_PORT_W)
  ) second_sync_inst (
    .ref_clk(ref_clk),
    .reset(reset),
    .async_in(second_port_pins_in),
    .sync_out(second_sync)
  );

  pin_sync #(
    .WIDTH(THIRD_PORT_W)
  ) third_sync_inst (
    .ref_clk(ref_clk),
    .reset(reset),
    .async_in(third_port_pins_in),
    .sync_out(third_sync)
  );

  // ----------------------------------------------------------------
  // Decode and read view
  // ----------------------------------------------------------------
  assign sel = decode_port(file_addr);
  assign bit_op = bit_set_instruction | bit_clear_instruction;
  // A direction load owns its cycle and blocks any store
  assign store_en = (file_write | bit_op) & ~dir_load;

  // ----------------------------------------------------------------
  // Per-port strobes
  // ----------------------------------------------------------------
  assign first_store = strobe_for(store_en, sel, SEL_FIRST);
  assign second_store = strobe_for(store_en, sel, SEL_SECOND);
  assign third_store = strobe_for(store_en, sel, SEL_THIRD);
  assign first_dir_load = strobe_for(dir_load, sel, SEL_FIRST);
  assign second_dir_load = strobe_for(dir_load, sel, SEL_SECOND);
  // Without the third port the location has no direction bits
  assign third_dir_load = strobe_for(dir_load, sel, SEL_THIRD) &&
                          HAS_THIRD_PORT;

  always_comb begin
    read_view = DATA_ZERO;
    unique case (sel)
      SEL_FIRST: begin
        read_view = {FIRST_UPPER_FILL, first_sync};
      end
      SEL_SECOND: begin
        read_view = second_sync;
      end
      SEL_THIRD: begin
        if (HAS_THIRD_PORT) begin
          read_view = third_sync;
        end else begin
          read_view = third_port_latch;
        end
      end
      SEL_NONE: begin
        read_view = DATA_ZERO;
      end
    endcase
  end

  // Bit ops modify the pin image, not the latch image
  always_comb begin
    if (bit_op) begin
      next_store = apply_bit(read_view, bit_sel,
                             bit_set_instruction);
    end else begin
      next_store = file_wdata;
    end
  end

  // ----------------------------------------------------------------
  // Output latches, no reset so values survive warm resets
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (first_store) begin
      first_port_latch <= next_store[FIRST_PORT_W-1:0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (second_store) begin
      second_port_latch <= next_store;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (third_store) begin
      third_port_latch <= next_store;
    end
  end

  // ----------------------------------------------------------------
  // Direction registers, write-only
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      first_port_direction <= DIR_RESET[FIRST_PORT_W-1:0];
    end else if (first_dir_load) begin
      first_port_direction <= file_wdata[FIRST_PORT_W-1:0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      second_port_direction <= DIR_RESET;
    end else if (second_dir_load) begin
      second_port_direction <= file_wdata;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      third_port_direction <= DIR_RESET;
    end else if (third_dir_load) begin
      third_port_direction <= file_wdata;
    end
  end

  // ----------------------------------------------------------------
  // Read data, sampled from the pins at the start of the cycle
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      file_rdata <= DATA_ZERO;
      file_hit <= 1'b0;
    end else if (file_read) begin
      file_rdata <= read_view;
      file_hit <= (sel != SEL_NONE);
    end else begin
      file_hit <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Pin drivers
  // ----------------------------------------------------------------
  always_comb begin
    first_drive.level = {FIRST_UPPER_FILL, first_port_latch};
    first_drive.enable = {FIRST_UPPER_FILL,
                          ~first_port_direction};
    second_drive.level = second_port_latch;
    second_drive.enable = ~second_port_direction;
    if (HAS_THIRD_PORT) begin
      third_drive.level = third_port_latch;
      third_drive.enable = ~third_port_direction;
    end else begin
      third_drive.level = DATA_ZERO;
      third_drive.enable = DATA_ZERO;
    end
  end

  assign first_port_pins_out = first_drive.level[FIRST_PORT_W-1:0];
  assign first_port_pins_oe = first_drive.enable[FIRST_PORT_W-1:0];
  assign second_port_pins_out = second_drive.level;
  assign second_port_pins_oe = second_drive.enable;
  assign third_port_pins_out = third_drive.level;
  assign third_port_pins_oe = third_drive.enable;

  // ----------------------------------------------------------------
  // Drive conflict status, for a pin held against its driver
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      drive_conflict <= 3'b000;
    end else begin
      drive_conflict[0] <= mismatch({FIRST_UPPER_FILL, first_sync},
                                    first_drive.level,
                                    first_drive.enable);
      drive_conflict[1] <= mismatch(second_sync, second_drive.level,
                                    second_drive.enable);
      drive_conflict[2] <= mismatch(third_sync, third_drive.level,
                                    third_drive.enable);
    end
  end

endmodule
`default_nettype wire

// File: bidir_io_ports_properties.sv
`timescale 1ns/1ps
`default_nettype none
module bidir_io_ports_properties
  import bidir_io_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // Instruction path
  input wire logic [ADDR_W-1:0] file_addr,
  input wire logic file_read,
  input wire logic file_write,
  input wire logic [DATA_W-1:0] file_wdata,
  input wire logic [DATA_W-1:0] file_rdata,
  input wire logic file_hit,
  input wire logic bit_set_instruction,
  input wire logic bit_clear_instruction,
  input wire logic [BIT_SEL_W-1:0] bit_sel,
  input wire logic dir_load,
  // Pins
  input wire logic [FIRST_PORT_W-1:0] first_port_pins_oe,
  input wire logic [SECOND_PORT_W-1:0] second_port_pins_in,
  input wire logic [SECOND_PORT_W-1:0] second_port_pins_out,
  input wire logic [SECOND_PORT_W-1:0] second_port_pins_oe,
  input wire logic [THIRD_PORT_W-1:0] third_port_pins_oe
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  logic at_b, b_op, b_known = 1'b0;
  assign at_b = file_addr == SECOND_PORT_ADDR;
  assign b_op = at_b && (file_write || bit_set_instruction
    || bit_clear_instruction);
  // Latch is unknown until first written
  always_ff @(posedge ref_clk) begin
    if (b_op && !dir_load) begin
      b_known <= 1'b1;
    end
  end
  sequence pins_settled;
    $stable(second_port_pins_in) [*3];
  endsequence
  sequence clear_b;
    pins_settled ##0 (bit_clear_instruction && !bit_set_instruction
      && !dir_load && at_b);
  endsequence
  reset_floats_a: assert property (
    $fell(reset) |-> {first_port_pins_oe, second_port_pins_oe,
      third_port_pins_oe} == 20'h00000) else $error("pins not floated");
  dir_load_a: assert property (
    dir_load && at_b |=> second_port_pins_oe == ~$past(file_wdata))
    else $error("direction load wrong");
  dir_hold_a: assert property (
    !dir_load |=> $stable(second_port_pins_oe))
    else $error("direction changed without load");
  latch_write_a: assert property (
    file_write && at_b && !dir_load && !bit_set_instruction
      && !bit_clear_instruction |=> second_port_pins_out == $past(file_wdata))
    else $error("latch write wrong");
  latch_hold_a: assert property (
    b_known && !b_op |=> $stable(second_port_pins_out))
    else $error("latch changed without write");
  upper_zero_a: assert property (
    file_read && file_addr == FIRST_PORT_ADDR |=>
      file_rdata[7:4] == FIRST_UPPER_FILL) else $error("upper bits set");
  hit_pulse_a: assert property (
    file_read && at_b ##1 !file_read |-> file_hit ##1 !file_hit)
    else $error("hit pulse wrong");
  read_pins_a: assert property (
    pins_settled ##0 (file_read && at_b) |=>
      file_rdata == $past(second_port_pins_in)) else $error("read not pins");
  bit_clear_a: assert property (
    clear_b |=> second_port_pins_out ==
      ($past(second_port_pins_in) & ~(8'h01 << $past(bit_sel))))
    else $error("bit clear wrong");
endmodule
bind bidir_io_ports bidir_io_ports_properties i_props (.ref_clk, .reset,
  .file_addr, .file_read, .file_write, .file_wdata, .file_rdata, .file_hit,
  .bit_set_instruction, .bit_clear_instruction, .bit_sel, .dir_load,
  .first_port_pins_oe, .second_port_pins_in, .second_port_pins_out,
  .second_port_pins_oe, .third_port_pins_oe);
`default_nettype wire

// File: pin_sync.sv
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // Asynchronous levels in, synchronised levels out
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage_one;

  // ----------------------------------------------------------------
  // Two flip-flop synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      stage_one <= '0;
      sync_out <= '0;
    end else begin
      stage_one <= async_in;
      sync_out <= stage_one;
    end
  end

endmodule
`default_nettype wire

// File: tb_bidir_io_ports.sv
`timescale 1ns/1ps
`default_nettype none
module tb_bidir_io_ports;
  import bidir_io_pkg::*;
  // --------
  // Signals
  // --------
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic [ADDR_W-1:0] file_addr = '0;
  logic file_read = 1'b0;
  logic file_write = 1'b0;
  logic dir_load = 1'b0;
  logic bit_set_instruction = 1'b0;
  logic bit_clear_instruction = 1'b0;
  logic [BIT_SEL_W-1:0] bit_sel = '0;
  logic [DATA_W-1:0] file_wdata = '0;
  logic [DATA_W-1:0] file_rdata;
  logic file_hit, h;
  logic [3:0] a_in, a_out, a_oe;
  logic [7:0] b_in, b_out, b_oe, c_in, c_out, c_oe;
  logic [7:0] p_rdata, p_c_out, p_c_oe;
  int plat;
  logic [7:0] ext [3] = '{8'h00, 8'h00, 8'h00};
  int lat [3], dir [3], ua [4] = '{0, 4, 8, 31};
  int p, num_errors = 0, compares = 0;
  integer seed = 32'h5C4D;
  always #5 ref_clk = ~ref_clk;
  bidir_io_ports i_dut (
    .ref_clk, .reset, .file_addr, .file_read, .file_write, .file_wdata,
    .file_rdata, .file_hit, .bit_set_instruction, .bit_clear_instruction,
    .bit_sel, .dir_load, .first_port_pins_in(a_in),
    .first_port_pins_out(a_out), .first_port_pins_oe(a_oe),
    .second_port_pins_in(b_in), .second_port_pins_out(b_out),
    .second_port_pins_oe(b_oe), .third_port_pins_in(c_in),
    .third_port_pins_out(c_out), .third_port_pins_oe(c_oe),
    .drive_conflict()
  );
  // Variant whose third location is a plain register
  bidir_io_ports #(.HAS_THIRD_PORT(1'b0)) i_dut_plain (
    .ref_clk, .reset, .file_addr, .file_read, .file_write, .file_wdata,
    .file_rdata(p_rdata), .file_hit(), .bit_set_instruction,
    .bit_clear_instruction, .bit_sel, .dir_load,
    .first_port_pins_in(a_in), .first_port_pins_out(),
    .first_port_pins_oe(), .second_port_pins_in(b_in),
    .second_port_pins_out(), .second_port_pins_oe(),
    .third_port_pins_in(c_in), .third_port_pins_out(p_c_out),
    .third_port_pins_oe(p_c_oe), .drive_conflict()
  );
  bidir_io_board #(.W(4)) i_board_a (.drv(a_out), .oe(a_oe),
    .ext(ext[0][3:0]), .pins(a_in));
  bidir_io_board i_board_b (.drv(b_out), .oe(b_oe), .ext(ext[1]), .pins(b_in));
  bidir_io_board i_board_c (.drv(c_out), .oe(c_oe), .ext(ext[2]), .pins(c_in));
  // --------
  // Model and tasks
  // --------
  function automatic int msk(int q);
    return q == 0 ? 'hF : 'hFF;
  endfunction
  function automatic logic [7:0] pinv(int q);
    return 8'(((lat[q] & ~dir[q]) | (ext[q] & dir[q])) & msk(q));
  endfunction
  function automatic logic [7:0] seen(int q, bit oe);
    case (q)
      0: return oe ? {4'h0, a_oe} : {4'h0, a_out};
      1: return oe ? b_oe : b_out;
      default: return oe ? c_oe : c_out;
    endcase
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %0t seen %h expected %h", $time, got, exp);
    end
  endtask
  // Idle first so pins pass the synchroniser
  task automatic cyc(input int a, input logic [4:0] k,
                     input logic [7:0] d, input int s);
    repeat (3) @(negedge ref_clk);
    file_addr = 5'(a);
    {bit_clear_instruction, bit_set_instruction, dir_load, file_write,
     file_read} = k;
    file_wdata = d;
    bit_sel = s[2:0];
    @(negedge ref_clk);
    h = file_hit;
    {bit_clear_instruction, bit_set_instruction, dir_load, file_write,
     file_read} = 5'h00;
  endtask
  task automatic wr(input int q, input int d);
    lat[q] = d & msk(q);
    if (q == 2) plat = lat[q];
    cyc(FIRST_PORT_ADDR + q, 5'h02, 8'(d), 0);
    chk(seen(q, 0), 8'(lat[q]));
  endtask
  task automatic ld(input int q, input int d);
    dir[q] = d & msk(q);
    cyc(FIRST_PORT_ADDR + q, 5'h04, 8'(d), 0);
    chk(seen(q, 1), 8'(~dir[q] & msk(q)));
  endtask
  task automatic rd(input int q);
    cyc(FIRST_PORT_ADDR + q, 5'h01, 8'h00, 0);
    chk({7'h00, h}, 8'h01);
    chk(file_rdata, pinv(q));
    if (q == 2) begin
      chk(p_rdata, 8'(plat));
      chk(p_c_out | p_c_oe, 8'h00);
    end
  endtask
  task automatic bop(input int q, input int s, input bit set);
    lat[q] = set ? pinv(q) | (1 << s) : pinv(q) & ~(1 << s);
    lat[q] &= msk(q);
    if (q == 2) plat = (set ? plat | (1 << s) : plat & ~(1 << s)) & 'hFF;
    cyc(FIRST_PORT_ADDR + q, set ? 5'h08 : 5'h10, 8'h00, s);
    chk(seen(q, 0), 8'(lat[q]));
  endtask
  task automatic tally_and_finish;
    $display("compares %0d errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // --------
  // Tests
  // --------
  initial begin
    repeat (6) @(negedge ref_clk);
    reset = 1'b0;
    for (int q = 0; q < 3; q++) chk(seen(q, 1), 8'h00);
    for (int r = 0; r < 4; r++) begin
      for (int i = 0; i < 3; i++) begin
        p = (i + 1) % 3;
        ext[p] = 8'($random(seed));
        wr(p, $random(seed));
        ld(p, r == 0 ? 'hFF : r == 1 ? 0 : $random(seed));
        rd(p);
      end
    end
    $display("test direction and read done");
    for (int i = 0; i < 12; i++) begin
      p = i % 3;
      ext[p] = 8'($random(seed));
      bop(p, $random(seed) & (p == 0 ? 3 : 7), (i / 3) % 2);
    end
    $display("test bit operations done");
    foreach (ua[k]) begin
      cyc(ua[k], 5'h03, 8'h5A, 0);
      chk(file_rdata, 8'h00);
      chk({7'h00, h}, 8'h00);
      for (int q = 0; q < 3; q++) chk(seen(q, 0), 8'(lat[q]));
    end
    $display("test unmapped done");
    reset = 1'b1;
    repeat (2) @(negedge ref_clk);
    reset = 1'b0;
    for (int q = 0; q < 3; q++) begin
      dir[q] = msk(q);
      chk(seen(q, 1), 8'h00);
      chk(seen(q, 0), 8'(lat[q]));
      rd(q);
    end
    $display("test second reset done");
    tally_and_finish();
  end
  // Tests need well under 1000 cycles
  initial begin
    #50000;
    num_errors++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
